// ---- sscs_cfg.svh ----
/*
 * Register map, field positions and reset values of the serial shift
 * clock select block.
 * Assumes byte addresses on a 32-bit Avalon-MM slave, one word per register.
 */
`ifndef SSCS_CFG_SVH
`define SSCS_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSCS_ADDR_CTRL 5'h00
`define SSCS_ADDR_PINPOS 5'h04
`define SSCS_ADDR_DATA 5'h08
`define SSCS_ADDR_STATUS 5'h0c
`define SSCS_ADDR_RXQ 5'h10
`define SSCS_ADDR_DIR 5'h14

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SSCS_CTRL_TOGGLE 0
`define SSCS_CTRL_STROBE 1
`define SSCS_CTRL_SELLO 2
`define SSCS_CTRL_SELHI 3
`define SSCS_CTRL_WMLO 4
`define SSCS_CTRL_IELO 6

// ----------------------------------------------------------------
// other fields
// ----------------------------------------------------------------
`define SSCS_PINPOS_SEL 0
`define SSCS_DIR_CLK 0
`define SSCS_DIR_DO 1
`define SSCS_STAT_NONEMPTY 4
`define SSCS_STAT_FULL 5
`define SSCS_STAT_PENDING 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SSCS_RST_CTRL 6'h00
`define SSCS_RST_PINPOS 1'h0
`define SSCS_RST_DIR 2'h0
`define SSCS_RST_DATA 8'h00
`define SSCS_RST_CNT 4'h0

`endif

// ---- sscs_pkg.sv ----
/*
 * Types shared by the serial shift clock select block.
 * Assumes sscs_cfg.svh supplies all numeric constants.
 */
package sscs_pkg;

	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_STROBE = 3'b001,
		SRC_TIMER = 3'b010,
		SRC_EXT_EDGES = 3'b011,
		SRC_EXT_TOGGLE = 3'b100
	} sscs_src_t;

	typedef struct packed {
		logic [5:0] ctrlHi;
		logic strobeSel;
		logic pinPos;
		logic dirClk;
		logic dirDo;
		logic [7:0] shiftData;
		logic [3:0] cnt;
		logic clkPort;
		logic dout;
		logic [1:0] sck1;
		logic [1:0] sck2;
		logic sck3;
		logic [1:0] din1;
		logic [1:0] din2;
		logic dinPrev;
		logic pending;
		logic [7:0] pendData;
		logic ack;
		logic [31:0] rdata;
	} sscs_state_t;

endpackage

// ---- sscs_fifo_if.sv ----
/*
 * Valid/ready carrier between the shift logic and its byte FIFO.
 * Assumes both ends run on the same clock.
 */
interface sscs_fifo_if #(parameter int WIDTH = 8);
	logic inValid;
	logic inReady;
	logic [WIDTH-1:0] inData;
	logic outValid;
	logic outReady;
	logic [WIDTH-1:0] outData;

	modport fifo (input inValid, input inData, input outReady,
		output inReady, output outValid, output outData);
	modport user (output inValid, output inData, output outReady,
		input inReady, input outValid, input outData);
endinterface

// ---- sscs_fifo.sv ----
/*
 * Synchronous FIFO of flip-flops with valid/ready on both sides.
 * Assumes DEPTH is a power of two.
 */
module sscs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	sscs_fifo_if.fifo q // push and pop sides
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} sscs_fifo_st_t;

	sscs_fifo_st_t st;
	sscs_fifo_st_t next_st;
	logic full;
	logic empty;

	assign empty = (st.wp == st.rp);
	assign full = (st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]);
	assign q.inReady = ~full;
	assign q.outValid = ~empty;
	assign q.outData = st.mem[st.rp[AW-1:0]];

	always_comb
	begin
		next_st = st;
		if (q.inValid && !full)
		begin
			next_st.mem[st.wp[AW-1:0]] = q.inData;
			next_st.wp = st.wp + 1'b1;
		end
		if (q.outReady && !empty)
			next_st.rp = st.rp + 1'b1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end
endmodule // sscs_fifo

// ---- sscs_top.sv ----
/*
 * Clock source select, strobe and toggle logic of a serial shift port,
 * with 8-bit shift register, 4-bit transfer counter and received-byte FIFO.
 * Assumes an Avalon-MM master on clk and pins from outside the clock domain.
 */
// Design decisions made here: register access over Avalon-MM and the address map.
// Notes on behaviour
// RL1 - external clock: output moves on opposite edge
// RL2 - strobe or timer: output latch is transparent
// RL3 - select 00/01 picks none, strobe, timer
// RL4 - external: low select bit picks edge
// RL5 - strobe write shifts data, increments counter
// RL6 - strobe: output now, input from cycle before
// RL7 - external: stored strobe bit selects toggle counting
// RL8 - toggle write inverts clock port always
// RL9 - external plus selector: toggle advances counter
// RL10 - strobe and toggle bits read zero
// RL11 - pin-position bits 7:1 read zero
// RL12 - position bit routes pins B or A
// RL13 - master toggles clock with pin as output
// RL14 - strobe and toggle are one-cycle pulses
`include "sscs_cfg.svh"

module sscs_top #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk, // system clock, 100 MHz
	input wire logic resetn, // async reset, active low
	input wire logic [4:0] address, // byte address
	input wire logic read, // read request
	input wire logic write, // write request
	input wire logic [3:0] byteenable, // byte lanes
	input wire logic [31:0] writedata, // write data
	output logic [31:0] readdata, // read data
	output logic waitrequest, // stall
	input wire logic timerZeroMatch, // timer zero compare pulse
	input wire logic [1:0] serialDataIn, // data in, [0] port B, [1] A
	output logic [1:0] serialDataOut, // data out per position
	output logic [1:0] serialDataOutOe, // data out enable
	input wire logic [1:0] serialClockPinIn, // clock pin level
	output logic [1:0] serialClockPinOut, // clock pin drive
	output logic [1:0] serialClockPinOe // clock pin enable
);

	sscs_pkg::sscs_state_t st;
	sscs_pkg::sscs_state_t next_st;
	sscs_pkg::sscs_src_t src;
	sscs_fifo_if #(.WIDTH(8)) rxq ();

	logic busy;
	logic take;
	logic wrTaken;
	logic wrCtrl;
	logic strobeW;
	logic togW;
	logic [1:0] effSel;
	logic effStrobeSel;
	logic sckS;
	logic rise;
	logic fall;
	logic hold;
	logic shiftClk;
	logic cntClk;
	logic outEdge;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic sscs_pkg::sscs_src_t decodeSrc(input logic [1:0] sel,
		input logic stb);
		sscs_pkg::sscs_src_t r;
		r = sscs_pkg::SRC_NONE;
		case (sel)
			2'h0: r = stb ? sscs_pkg::SRC_STROBE : sscs_pkg::SRC_NONE;
			2'h1: r = sscs_pkg::SRC_TIMER;
			default: r = stb ? sscs_pkg::SRC_EXT_TOGGLE
				: sscs_pkg::SRC_EXT_EDGES;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] readMux(input logic [4:0] a,
		input sscs_pkg::sscs_state_t s, input logic ne, input logic fl,
		input logic [7:0] head);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`SSCS_ADDR_CTRL: r = {24'h00_0000, s.ctrlHi, 2'h0}; // RL10
			`SSCS_ADDR_PINPOS: r = {31'h0000_0000, s.pinPos}; // RL11
			`SSCS_ADDR_DATA: r = {24'h00_0000, s.shiftData};
			`SSCS_ADDR_STATUS: r = {25'h000_0000, s.pending, fl, ne, s.cnt};
			`SSCS_ADDR_RXQ: r = {24'h00_0000, ne ? head : 8'h00};
			`SSCS_ADDR_DIR: r = {30'h0000_0000, s.dirDo, s.dirClk};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		busy = (read || write) && !st.ack;
		take = (read || write) && st.ack;
		wrTaken = take && write && byteenable[0];
		wrCtrl = wrTaken && (address == `SSCS_ADDR_CTRL);
		// write-action bits exist only for the taking cycle
		strobeW = wrCtrl && writedata[`SSCS_CTRL_STROBE]; // RL14
		togW = wrCtrl && writedata[`SSCS_CTRL_TOGGLE]; // RL14
		effSel = wrCtrl ? writedata[`SSCS_CTRL_SELHI:`SSCS_CTRL_SELLO]
			: st.ctrlHi[1:0];
		effStrobeSel = wrCtrl ? writedata[`SSCS_CTRL_STROBE] : st.strobeSel;
		src = decodeSrc(effSel, effStrobeSel); // RL3
		next_st.ack = busy;

		// pin synchronisers, edges seen after the second stage
		next_st.sck1 = serialClockPinIn;
		next_st.sck2 = st.sck1;
		sckS = st.sck2[st.pinPos]; // RL12
		next_st.sck3 = sckS;
		rise = sckS && !st.sck3;
		fall = !sckS && st.sck3;
		next_st.din1 = serialDataIn;
		next_st.din2 = st.din1;
		next_st.dinPrev = st.din2[st.pinPos]; // RL12

		// a finished byte that the FIFO cannot take freezes the port
		hold = st.pending && !rxq.inReady;
		shiftClk = 1'b0;
		cntClk = 1'b0;
		case (src)
			sscs_pkg::SRC_STROBE:
			begin
				shiftClk = strobeW; // RL5
				cntClk = strobeW; // RL5
			end
			sscs_pkg::SRC_TIMER:
			begin
				shiftClk = timerZeroMatch; // RL3
				cntClk = timerZeroMatch; // RL3
			end
			sscs_pkg::SRC_EXT_EDGES:
			begin
				shiftClk = effSel[0] ? fall : rise; // RL4
				cntClk = rise || fall; // RL4
			end
			sscs_pkg::SRC_EXT_TOGGLE:
			begin
				shiftClk = effSel[0] ? fall : rise; // RL7
				cntClk = togW; // RL9
			end
			default:
			begin
				shiftClk = 1'b0;
				cntClk = 1'b0;
			end
		endcase
		shiftClk = shiftClk && !hold;
		cntClk = cntClk && !hold;
		outEdge = effSel[0] ? rise : fall;

		if (shiftClk)
			next_st.shiftData = {st.shiftData[6:0], st.dinPrev}; // RL6
		if (cntClk)
			next_st.cnt = st.cnt + 4'h1;
		if (st.pending && rxq.inReady)
			next_st.pending = 1'b0;
		if (cntClk && (st.cnt == 4'hf))
		begin
			next_st.pending = 1'b1;
			next_st.pendData = next_st.shiftData;
		end
		if (togW)
			next_st.clkPort = !st.clkPort; // RL8

		// register writes win over a shift in the same cycle
		if (wrTaken)
		begin
			case (address)
				`SSCS_ADDR_CTRL:
				begin
					next_st.ctrlHi = writedata[7:2];
					next_st.strobeSel = writedata[`SSCS_CTRL_STROBE]; // RL7
				end
				`SSCS_ADDR_PINPOS:
					next_st.pinPos = writedata[`SSCS_PINPOS_SEL]; // RL12
				`SSCS_ADDR_DATA:
					next_st.shiftData = writedata[7:0];
				`SSCS_ADDR_STATUS:
					next_st.cnt = writedata[3:0];
				`SSCS_ADDR_DIR:
				begin
					next_st.dirClk = writedata[`SSCS_DIR_CLK];
					next_st.dirDo = writedata[`SSCS_DIR_DO];
				end
				default:
					next_st.cnt = next_st.cnt;
			endcase
		end

		// output latch
		if (!next_st.ctrlHi[1])
			next_st.dout = next_st.shiftData[7]; // RL2
		else if (outEdge && !hold)
			next_st.dout = st.shiftData[7]; // RL1

		if (busy && read)
			next_st.rdata = readMux(address, st, rxq.outValid, !rxq.inReady,
				rxq.outData);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.ctrlHi <= `SSCS_RST_CTRL;
			st.pinPos <= `SSCS_RST_PINPOS;
			st.dirClk <= 1'(`SSCS_RST_DIR >> `SSCS_DIR_CLK);
			st.dirDo <= 1'(`SSCS_RST_DIR >> `SSCS_DIR_DO);
			st.shiftData <= `SSCS_RST_DATA;
			st.cnt <= `SSCS_RST_CNT;
		end
		else
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// FIFO and pins
	// ----------------------------------------------------------------
	assign rxq.inValid = st.pending;
	assign rxq.inData = st.pendData;
	assign rxq.outReady = take && read && (address == `SSCS_ADDR_RXQ);

	sscs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxq (
		.clk(clk),
		.resetn(resetn),
		.q(rxq)
	);

	assign readdata = st.rdata;
	assign waitrequest = busy;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_pos
			// unselected position is released to normal port use
			assign serialDataOut[gi] = st.dout;
			assign serialDataOutOe[gi] = st.dirDo && (st.pinPos == 1'(gi)); // RL12
			assign serialClockPinOut[gi] = st.clkPort;
			assign serialClockPinOe[gi] = st.dirClk && (st.pinPos == 1'(gi)); // RL13
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_extOutEdge;
		(st.ctrlHi[1] && !wrTaken && !hold && !st.ctrlHi[0] && fall)
			|=> (st.dout == $past(st.shiftData[7]));
	endproperty
	a_extOutEdge: assert property (p_extOutEdge) // RL1
		else $error("external mode output not moved on falling edge");

	property p_extSampleHolds;
		(st.ctrlHi[1] && !wrTaken && !st.ctrlHi[0] && rise) |=> $stable(st.dout);
	endproperty
	a_extSampleHolds: assert property (p_extSampleHolds) // RL1
		else $error("output moved on sampling edge");

	property p_transparent;
		(!st.ctrlHi[1] && !wrTaken) |=> (st.dout == st.shiftData[7]);
	endproperty
	a_transparent: assert property (p_transparent) // RL2
		else $error("output latch not transparent");

	property p_timerCount;
		(effSel == 2'h1 && timerZeroMatch && !hold && !wrTaken)
			|=> (st.cnt == $past(st.cnt) + 4'h1);
	endproperty
	a_timerCount: assert property (p_timerCount) // RL3
		else $error("timer match did not advance counter");

	property p_bothEdges;
		(st.ctrlHi[1] && !st.strobeSel && (rise || fall) && !hold && !wrTaken)
			|=> (st.cnt == $past(st.cnt) + 4'h1);
	endproperty
	a_bothEdges: assert property (p_bothEdges) // RL4
		else $error("pin edge did not advance counter");

	property p_strobe;
		(strobeW && writedata[3:2] == 2'h0 && !hold)
			|=> (st.cnt == $past(st.cnt) + 4'h1)
			&& (st.shiftData == {$past(st.shiftData[6:0]), $past(st.dinPrev)})
			&& (st.dout == st.shiftData[7]);
	endproperty
	a_strobe: assert property (p_strobe) // RL5
		else $error("strobe did not shift and count");

	property p_selectorBlocksEdges;
		(st.ctrlHi[1] && st.strobeSel && !togW && !wrTaken) |=> $stable(st.cnt);
	endproperty
	a_selectorBlocksEdges: assert property (p_selectorBlocksEdges) // RL7
		else $error("counter moved without toggle strobe");

	property p_toggle;
		togW |=> (st.clkPort != $past(st.clkPort)) ##1 $stable(st.clkPort);
	endproperty
	a_toggle: assert property (p_toggle) // RL8
		else $error("toggle write did not invert clock port");

	property p_toggleCounts;
		(togW && writedata[3] && writedata[1] && !hold)
			|=> (st.cnt == $past(st.cnt) + 4'h1);
	endproperty
	a_toggleCounts: assert property (p_toggleCounts) // RL9
		else $error("toggle did not advance counter");

	property p_ctrlReadZero;
		(take && read && address == `SSCS_ADDR_CTRL) |-> (readdata[1:0] == 2'h0);
	endproperty
	a_ctrlReadZero: assert property (p_ctrlReadZero) // RL10
		else $error("write-action bits read nonzero");

	property p_pinposReadZero;
		(take && read && address == `SSCS_ADDR_PINPOS)
			|-> (readdata[31:1] == 31'h0000_0000);
	endproperty
	a_pinposReadZero: assert property (p_pinposReadZero) // RL11
		else $error("reserved position bits read nonzero");

	property p_route;
		st.pinPos |-> !serialDataOutOe[0] && !serialClockPinOe[0]
			&& (serialDataOutOe[1] == st.dirDo);
	endproperty
	a_route: assert property (p_route) // RL12
		else $error("pins not routed to alternate position");

	property p_strobePulse;
		(strobeW && writedata[3:2] == 2'h0 && !hold)
			##1 (!wrTaken && !timerZeroMatch) |=> $stable(st.cnt);
	endproperty
	a_strobePulse: assert property (p_strobePulse) // RL14
		else $error("strobe acted for more than one cycle");
endmodule // sscs_top

// ---- sscs_serial_partner.sv ----
/*
 * Far-side serial device: makes the link clock and data for one frame.
 * Assumes the device sits in external clock mode while a frame runs.
 */
module sscs_serial_partner (
	input wire logic go, // start one frame
	input wire logic negSample, // take device data on falling edge
	input wire logic [7:0] txByte, // byte sent, msb first
	input wire logic devOut, // device data output
	output logic sck, // link clock, still between frames
	output logic sdi, // data toward the device
	output logic busy, // frame in progress
	output logic [7:0] rxByte // bits taken from the device
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// frame generator
	// ----------------------------------------------------------------
	initial
	begin
		sck = 1'b0;
		sdi = 1'b0;
		busy = 1'b0;
		rxByte = 8'h00;
	end

	// data held a quarter period around both edges, 160 ns per bit
	always @(posedge go)
	begin
		busy = 1'b1;
		#3;
		for (int i = 7; i >= 0; i--)
		begin
			sdi = txByte[i];
			#40 sck = 1'b1;
			if (!negSample)
				rxByte = {rxByte[6:0], devOut};
			#80 sck = 1'b0;
			if (negSample)
				rxByte = {rxByte[6:0], devOut};
			#40;
		end
		// no pull on the line: show the inverse once released
		sdi = ~sdi;
		busy = 1'b0;
	end
endmodule // sscs_serial_partner

// ---- sscs_top_tb.sv ----
/*
 * Self-checking bench of the serial shift clock select block.
 * Assumes the register map of sscs_cfg.svh and a slave that stalls on
 * waitrequest for as long as it likes.
 */
`include "sscs_cfg.svh"
module sscs_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam logic [4:0] A_CT = `SSCS_ADDR_CTRL;
	localparam logic [4:0] A_PP = `SSCS_ADDR_PINPOS;
	localparam logic [4:0] A_DA = `SSCS_ADDR_DATA;
	localparam logic [4:0] A_ST = `SSCS_ADDR_STATUS;
	localparam logic [4:0] A_RX = `SSCS_ADDR_RXQ;
	localparam logic [4:0] A_DR = `SSCS_ADDR_DIR;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic timerZeroMatch = 1'b0;
	logic tbDin = 1'b0;
	logic pinSel = 1'b0;
	logic go = 1'b0;
	logic negSample = 1'b0;
	logic [7:0] txByte = 8'h00;
	logic [31:0] readdata;
	logic waitrequest, sck, sdi, busy, dLine;
	logic [1:0] serialDataOut, serialDataOutOe, serialDataIn;
	logic [1:0] serialClockPinOut, serialClockPinOe, serialClockPinIn;
	logic [7:0] rxByte, model, d, tx;
	logic [3:0] cnt;
	logic [7:0] exq[$];
	int numErrors = 0;
	int compares = 0;

	always #5 clk = ~clk;
	// unselected data position sees the inverse and its clock pin sits low, so misrouting shows
	assign dLine = busy ? sdi : tbDin;
	assign serialDataIn = pinSel ? {dLine, ~dLine} : {~dLine, dLine};
	assign serialClockPinIn = pinSel ? {sck, 1'b0} : {1'b0, sck};

	sscs_top i_sscs_top (.clk(clk), .resetn(resetn), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .timerZeroMatch(timerZeroMatch),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.serialDataOutOe(serialDataOutOe),
		.serialClockPinIn(serialClockPinIn),
		.serialClockPinOut(serialClockPinOut),
		.serialClockPinOe(serialClockPinOe));

	sscs_serial_partner i_sscs_serial_partner (.go(go),
		.negSample(negSample), .txByte(txByte),
		.devOut(serialDataOut[pinSel]), .sck(sck), .sdi(sdi),
		.busy(busy), .rxByte(rxByte));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic logic [1:0] oeAt(input logic en, input logic p);
		return en ? (p ? 2'b10 : 2'b01) : 2'b00;
	endfunction

	task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			numErrors++;
			$display("BAD t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkPin(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp)
		begin
			numErrors++;
			$display("BAD t=%0t pin got %b exp %b", $time, got, exp);
		end
	endtask

	// values read right at the edge are the settled pre-edge ones
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [7:0] v, output logic [31:0] r);
		logic w;
		w = 1'b1;
		r = 32'h0;
		@(posedge clk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= {24'h0, v};
		byteenable <= 4'h1;
		// no count of wait states: a hang is left to the watchdog
		while (w !== 1'b0)
		begin
			@(posedge clk);
			w = waitrequest;
			r = readdata;
		end
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wreg(input logic [4:0] a, input logic [7:0] v);
		logic [31:0] x;
		bus(1'b1, a, v, x);
	endtask

	task automatic rreg(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 8'h00, x);
		chkReg(x, e);
	endtask

	// one shift clock from the strobe write or a timer pulse
	task automatic step(input logic b, input logic useTimer);
		tbDin <= b;
		repeat (4) @(posedge clk);
		if (useTimer)
		begin
			timerZeroMatch <= 1'b1;
			@(posedge clk);
			timerZeroMatch <= 1'b0;
		end
		else
			wreg(A_CT, 8'h02);
		model = {model[6:0], b};
		cnt++;
		@(negedge clk);
		chkPin(serialDataOut, {2{model[7]}});
		rreg(A_DA, {24'h0, model});
	endtask

	task automatic frame(input logic [7:0] v, input logic neg);
		txByte <= v;
		negSample <= neg;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy)
			@(posedge clk);
		repeat (8) @(posedge clk);
	endtask

	task automatic printVerdict;
		$display("compares %0d numErrors %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		// tests take about 3.5k cycles; allow over five times that
		#200_000;
		numErrors++;
		$display("BAD t=%0t watchdog", $time);
		printVerdict;
	end

	initial
	begin
		void'($urandom(32'h50c6807a));
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chkPin(serialDataOutOe, 2'b00);
		chkPin(serialClockPinOe, 2'b00);
		chkPin(serialClockPinOut, 2'b00);
		rreg(A_CT, 32'h0);
		rreg(A_DA, 32'h0);
		rreg(A_ST, 32'h0);
		rreg(A_DR, 32'h0);
		rreg(5'h18, 32'h0);
		wreg(A_PP, 8'hff);
		rreg(A_PP, 32'h1);
		wreg(A_CT, 8'hf0);
		rreg(A_CT, 32'hf0);
		$display("done registers");
		for (int p = 0; p < 2; p++)
		begin
			pinSel <= p[0];
			wreg(A_PP, {7'h0, p[0]});
			wreg(A_DR, 8'h03);
			@(negedge clk);
			chkPin(serialDataOutOe, oeAt(1'b1, p[0]));
			chkPin(serialClockPinOe, oeAt(1'b1, p[0]));
			wreg(A_ST, 8'h00);
			d = 8'($urandom);
			wreg(A_DA, d);
			model = d;
			cnt = 4'h0;
			wreg(A_CT, 8'h00);
			rreg(A_DA, {24'h0, model});
			repeat (6) step(1'($urandom), 1'b0);
			rreg(A_ST, {28'h0, cnt});
		end
		$display("done strobe");
		for (int k = 0; k < 4; k++)
		begin
			wreg(A_CT, k[1] ? 8'h06 : 8'h04);
			step(1'($urandom), 1'b1);
		end
		rreg(A_ST, {28'h0, cnt});
		$display("done timer");
		wreg(A_DR, 8'h00);
		wreg(A_CT, 8'h01);
		@(negedge clk);
		chkPin(serialClockPinOut, 2'b11);
		chkPin(serialClockPinOe, 2'b00);
		wreg(A_DR, 8'h01);
		@(negedge clk);
		chkPin(serialClockPinOe, oeAt(1'b1, pinSel));
		rreg(A_CT, 32'h0);
		wreg(A_CT, 8'h01);
		@(negedge clk);
		chkPin(serialClockPinOut, 2'b00);
		rreg(A_DA, {24'h0, model});
		$display("done toggle");
		wreg(A_ST, 8'h00);
		cnt = 4'h0;
		wreg(A_CT, 8'h0a);
		rreg(A_CT, 32'h08);
		repeat (3)
		begin
			wreg(A_CT, 8'h0b);
			cnt++;
		end
		rreg(A_ST, {28'h0, cnt});
		tx = 8'($urandom);
		frame(tx, 1'b0);
		rreg(A_DA, {24'h0, tx});
		rreg(A_ST, {28'h0, cnt});
		$display("done toggle count");
		for (int lo = 0; lo < 2; lo++)
		begin
			wreg(A_ST, 8'h00);
			d = 8'($urandom);
			wreg(A_DA, d);
			wreg(A_CT, lo[0] ? 8'h0c : 8'h08);
			tx = 8'($urandom);
			frame(tx, lo[0]);
			rreg(A_DA, {24'h0, tx});
			chkReg({25'h0, rxByte[6:0]}, {25'h0, d[6:0]});
			rreg(A_RX, {24'h0, tx});
			rreg(A_ST, 32'h0);
		end
		$display("done external");
		pinSel <= 1'b0;
		wreg(A_PP, 8'h00);
		wreg(A_CT, 8'h00);
		wreg(A_ST, 8'h00);
		wreg(A_DA, 8'h00);
		model = 8'h00;
		cnt = 4'h0;
		for (int k = 0; k < 17; k++)
		begin
			repeat (16) step(1'($urandom), 1'b0);
			if (k < 16)
				exq.push_back(model);
			if (k == 15)
				rreg(A_ST, 32'h30);
		end
		rreg(A_ST, 32'h70);
		wreg(A_CT, 8'h02);
		rreg(A_DA, {24'h0, model});
		rreg(A_ST, 32'h70);
		foreach (exq[i])
			rreg(A_RX, {24'h0, exq[i]});
		$display("done fifo");
		printVerdict;
	end
endmodule // sscs_top_tb
